/* hdl/config_fuses_and_watchdog.sv */
// Configuration option decode, part identifier and watchdog control.
// Assumes synchronous table reads and single-cycle instruction event pulses.
`timescale 1ns/1ps
`default_nettype none
module config_fuses_and_watchdog
  import cfg_wdt_pkg::*;
#(
  parameter int          base_cycles    = base_period_cyc,
  parameter logic [10:0] part_identifier = 11'h2a5,  // Arbitrary value
  parameter logic [4:0]  silicon_revision = 5'h01,   // Arbitrary value
  parameter bit          has_table_protect = 1'b1
)
(
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  // Configuration programming port
  input  wire logic              prog_write_in,
  input  wire logic [21:0]       prog_addr_in,
  input  wire logic [7:0]        prog_data_in,
  // Table read port
  input  wire logic              table_read_in,
  input  wire logic [21:0]       table_addr_in,
  input  wire logic              table_from_external_in,
  output logic [7:0]             table_data_out,
  output logic                   table_blocked_out,
  // Special function registers
  input  wire logic              sfr_write_in,
  input  wire logic [1:0]        sfr_addr_in,
  input  wire logic [7:0]        sfr_wdata_in,
  output logic [7:0]             sfr_rdata_out,
  // Core events
  input  wire cfg_wdt_pkg::wdt_clear_type wdt_events_in,
  input  wire logic              sleeping_in,
  input  wire logic              stack_fault_in,
  input  wire logic              master_reset_pin_n_in,
  input  wire logic              port_g_bit5_input_in,
  // Decoded outputs
  output cfg_wdt_pkg::config_decode_type config_out,
  output logic                   port_g_bit5_input_out,
  output logic                   table_read_protect_out,
  output logic                   internal_rc_clock_enable_out,
  output logic                   device_reset_out,
  output logic                   wake_out
);
  import cfg_wdt_pkg::*;

  // Power-on contents hold erased state; device reset does not disturb them
  logic [7:0]   pin_timer_q        = erased_pin_timer;
  logic [7:0]   debug_stack_q      = erased_debug;
  logic [7:0]   code_prot_q        = erased_protect;
  logic [7:0]   table_prot_q       = erased_protect;
  logic [7:0]   config_wdt_q       = erased_config_wdt;
  logic [7:0]   mode_q             = erased_mode;
  logic [7:0]   watchdog_control_q;
  logic         timeout_flag_n_q   = 1'b1;
  logic         wdt_enabled;
  logic         wdt_clear;
  logic         wdt_expire;
  logic         in_protected_range;
  mem_mode_type mode;
  logic [7:0]   table_data_d;

  // ==========================================================
  // Configuration bytes, erased to the package erased values; programming only clears
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pin_timer_q   <= pin_timer_q;
      debug_stack_q <= debug_stack_q;
    end
    else if (prog_write_in && prog_addr_in == addr_pin_timer_opts)
      pin_timer_q <= pin_timer_q & prog_data_in & erased_pin_timer | (prog_data_in & 8'h04 & pin_timer_q);
    else if (prog_write_in && prog_addr_in == addr_debug_stack)
      debug_stack_q <= debug_stack_q & prog_data_in & 8'h81 | (prog_data_in & 8'h40 & debug_stack_q);
  end

  always_ff @(posedge clk_in)
  begin
    if (prog_write_in && prog_addr_in == addr_code_protect)
      code_prot_q <= code_prot_q & (prog_data_in | ~erased_protect) & erased_protect;
  end

  always_ff @(posedge clk_in)
  begin
    if (prog_write_in && prog_addr_in == addr_table_protect && has_table_protect)
      table_prot_q <= table_prot_q & prog_data_in & erased_protect;
  end

  always_ff @(posedge clk_in)
  begin
    if (prog_write_in && prog_addr_in == addr_config_wdt)
      config_wdt_q <= config_wdt_q & prog_data_in & erased_config_wdt;
  end

  always_ff @(posedge clk_in)
  begin
    if (prog_write_in && prog_addr_in == addr_config_mode)
      mode_q <= mode_q & prog_data_in & erased_mode;
  end

  assign mode = mem_mode_type'(mode_q[1:0]);

  // ==========================================================
  // Option decode
  always_comb
  begin
    config_out.reset_pin_enable        = pin_timer_q[bit_reset_pin_enable];
    config_out.low_power_secondary_osc = pin_timer_q[bit_low_power_osc];
    if (pin_timer_q[bit_ccp2_route])
      config_out.ccp2_location = ccp2_on_port_c_bit1;
    else if (mode == mode_mcu)
      config_out.ccp2_location = ccp2_on_port_e_bit7;
    else
      config_out.ccp2_location = ccp2_on_port_b_bit3;
    config_out.debug_enabled         = !debug_stack_q[bit_debug_off];
    config_out.extended_instr_enable = debug_stack_q[bit_extended_instr];
    config_out.code_protect          = !code_prot_q[bit_code_protect];
  end

  // Pin input disabled while it serves as reset
  assign port_g_bit5_input_out = config_out.reset_pin_enable ? 1'b0 : port_g_bit5_input_in;

  // ==========================================================
  // Table read protection
  assign table_read_protect_out = !table_prot_q[bit_table_protect];
  always_comb
  begin
    in_protected_range = 1'b0;
    if (mode == mode_ext_mcu)
      in_protected_range = table_addr_in[21:20] == 2'h0;
    else if (mode == mode_mcu_boot)
      in_protected_range = table_addr_in <= {1'b0, boot_block_last};
  end
  assign table_blocked_out = table_read_in && table_from_external_in
                             && table_read_protect_out && in_protected_range;

  always_comb
  begin
    table_data_d = 8'h00;
    if (table_addr_in == addr_pin_timer_opts)
      table_data_d = pin_timer_q & 8'h85;
    else if (table_addr_in == addr_debug_stack)
      table_data_d = debug_stack_q & 8'hc1;
    else if (table_addr_in == addr_code_protect)
      table_data_d = code_prot_q;
    else if (table_addr_in == addr_table_protect)
      table_data_d = table_prot_q;
    else if (table_addr_in == addr_config_wdt)
      table_data_d = config_wdt_q;
    else if (table_addr_in == addr_config_mode)
      table_data_d = mode_q;
    else if (table_addr_in == addr_part_id_low)
      table_data_d = {part_identifier[2:0], silicon_revision};
    else if (table_addr_in == addr_part_id_high)
      table_data_d = part_identifier[10:3];
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      table_data_out <= 8'h00;
    else if (table_read_in && !table_blocked_out)
      table_data_out <= table_data_d;
  end

  // ==========================================================
  // Watchdog control and time-out flag
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      watchdog_control_q <= watchdog_ctrl_rst;
    else if (sfr_write_in && sfr_addr_in == sfr_watchdog_control)
      watchdog_control_q <= {7'h00, sfr_wdata_in[bit_sw_wdt_enable]};
  end

  assign wdt_enabled = config_wdt_q[bit_config_wdt_enable]
                       || watchdog_control_q[bit_sw_wdt_enable];
  assign internal_rc_clock_enable_out = wdt_enabled;
  assign wdt_clear = wdt_events_in.sleep_instr || wdt_events_in.clear_instr
                     || wdt_events_in.freq_changed || wdt_events_in.clock_failed;

  watchdog_core #(
    .base_cycles (base_cycles),
    .ps_width    (postscale_bits)
  ) u_core (
    .clk_in              (clk_in),
    .reset_in            (reset_in),
    .enable_in           (wdt_enabled),
    .clear_in            (wdt_clear),
    .postscale_select_in (config_wdt_q[4:1]),
    .expire_out          (wdt_expire)
  );

  // Flag is active low; expiry wins over a clearing instruction
  always_ff @(posedge clk_in)
  begin
    if (wdt_expire)
      timeout_flag_n_q <= 1'b0;
    else if (wdt_events_in.clear_instr || wdt_events_in.sleep_instr)
      timeout_flag_n_q <= 1'b1;
  end

  always_comb
  begin
    sfr_rdata_out = 8'h00;
    if (sfr_addr_in == sfr_watchdog_control)
      sfr_rdata_out = watchdog_control_q;
    else if (sfr_addr_in == sfr_reset_cause)
      sfr_rdata_out[bit_timeout_flag] = timeout_flag_n_q;
  end

  // ==========================================================
  // Reset and wake generation
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      device_reset_out <= 1'b0;
      wake_out         <= 1'b0;
    end
    else
    begin
      device_reset_out <= (wdt_expire && !sleeping_in)
                          || (stack_fault_in && debug_stack_q[bit_stack_reset])
                          || (config_out.reset_pin_enable && !master_reset_pin_n_in);
      wake_out         <= wdt_expire && sleeping_in;
    end
  end

endmodule
`default_nettype wire

/* hdl/watchdog_core.sv */
// Watchdog base tick counter and selectable postscaler.
// Assumes clk_in is the internal RC clock and clears arrive as one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module watchdog_core
  import cfg_wdt_pkg::*;
#(
  parameter int base_cycles = base_period_cyc,
  parameter int ps_width    = postscale_bits
)
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       enable_in,
  input  wire logic       clear_in,
  input  wire logic [3:0] postscale_select_in,
  output logic            expire_out
);
  import cfg_wdt_pkg::*;

  logic [23:0]         base_q;
  logic [ps_width-1:0] post_q;
  logic                tick;
  logic [ps_width:0]   post_next;

  // ==========================================================
  // Base tick
  assign tick = enable_in && (base_q == 24'(base_cycles - 1));

  always_ff @(posedge clk_in)
  begin
    if (reset_in || clear_in || !enable_in)
      base_q <= '0;
    else if (tick)
      base_q <= '0;
    else
      base_q <= base_q + 24'h1;
  end

  // ==========================================================
  // Postscaler, output 2^n ticks after clear
  assign post_next = {1'b0, post_q} + {{ps_width{1'b0}}, 1'b1};

  always_ff @(posedge clk_in)
  begin
    if (reset_in || clear_in || !enable_in)
      post_q <= '0;
    else if (tick)
      post_q <= post_next[ps_width-1:0];
  end

  // Expiry when the selected stage would toggle
  always_ff @(posedge clk_in)
  begin
    if (reset_in || clear_in)
      expire_out <= 1'b0;
    else
      expire_out <= tick && (post_next[postscale_select_in] != post_q[postscale_select_in])
                    && ((post_q & ((ps_width'(1) << postscale_select_in) - ps_width'(1)))
                        == ((ps_width'(1) << postscale_select_in) - ps_width'(1)));
  end

endmodule
`default_nettype wire

/* inc/cfg_wdt_pkg.sv */
// Package: configuration byte layout, register addresses and watchdog constants.
// Assumes a single 25 MHz clock that stands in for the internal RC clock.
package cfg_wdt_pkg;

  // ==========================================================
  // Register addresses (configuration space, byte addressed)
  localparam logic [21:0] addr_pin_timer_opts  = 22'h300005;
  localparam logic [21:0] addr_debug_stack     = 22'h300006;
  localparam logic [21:0] addr_code_protect    = 22'h300008;
  localparam logic [21:0] addr_table_protect   = 22'h30000c;
  localparam logic [21:0] addr_part_id_low     = 22'h3ffffe;
  localparam logic [21:0] addr_part_id_high    = 22'h3fffff;
  localparam logic [21:0] addr_config_wdt      = 22'h300003;
  localparam logic [21:0] addr_config_mode     = 22'h300004;

  // Special function register indices (own space, 2-bit)
  localparam logic [1:0]  sfr_watchdog_control = 2'h0;
  localparam logic [1:0]  sfr_reset_cause      = 2'h1;

  // ==========================================================
  // Field positions
  localparam int bit_reset_pin_enable   = 7;
  localparam int bit_low_power_osc      = 2;
  localparam int bit_ccp2_route         = 0;
  localparam int bit_debug_off          = 7;
  localparam int bit_extended_instr     = 6;
  localparam int bit_stack_reset        = 0;
  localparam int bit_code_protect       = 0;
  localparam int bit_table_protect      = 0;
  localparam int bit_config_wdt_enable  = 0;
  localparam int bit_sw_wdt_enable      = 0;
  localparam int bit_timeout_flag       = 3;

  // Erased values of configuration bytes and reset value of the watchdog control register
  localparam logic [7:0] erased_pin_timer  = 8'h81;
  localparam logic [7:0] erased_debug      = 8'h81;
  localparam logic [7:0] erased_protect    = 8'h01;
  localparam logic [7:0] erased_config_wdt = 8'h1f;
  localparam logic [7:0] erased_mode       = 8'hc3;
  localparam logic [7:0] watchdog_ctrl_rst = 8'h00;

  // Boot block bounds for table read protection
  localparam logic [20:0] boot_block_last = 21'h0007ff;

  // ==========================================================
  // Timing
  localparam int clock_hz          = 25_000_000;
  localparam int base_period_ms    = 4;
  localparam int base_period_cyc   = clock_hz / 1000 * base_period_ms;
  localparam int postscale_bits    = 16;

  typedef enum logic [1:0] {
    mode_ext_mcu,
    mode_mcu_boot,
    mode_mpu,
    mode_mcu
  } mem_mode_type;

  typedef struct packed {
    logic sleep_instr;
    logic clear_instr;
    logic freq_changed;
    logic clock_failed;
  } wdt_clear_type;

  typedef struct packed {
    logic       reset_pin_enable;
    logic       low_power_secondary_osc;
    logic [1:0] ccp2_location;
    logic       debug_enabled;
    logic       extended_instr_enable;
    logic       code_protect;
  } config_decode_type;

  // CCP2 pin locations
  localparam logic [1:0] ccp2_on_port_c_bit1 = 2'h0;
  localparam logic [1:0] ccp2_on_port_e_bit7 = 2'h1;
  localparam logic [1:0] ccp2_on_port_b_bit3 = 2'h2;

endpackage

/* tb/config_fuses_and_watchdog_checker.sv */
// Checker: pin, table read and watchdog relations at the top ports.
// Assumes the top instance runs with base_cycles of 4 or more.
`timescale 1ns/1ps
`default_nettype none
module config_fuses_and_watchdog_checker
  import cfg_wdt_pkg::*;
(
  input wire logic                            clk_in,
  input wire logic                            reset_in,
  input wire logic                            table_read_in,
  input wire logic                            table_from_external_in,
  input wire logic [7:0]                      table_data_out,
  input wire logic                            table_blocked_out,
  input wire cfg_wdt_pkg::wdt_clear_type      wdt_events_in,
  input wire logic                            sleeping_in,
  input wire logic                            master_reset_pin_n_in,
  input wire logic                            port_g_bit5_input_in,
  input wire cfg_wdt_pkg::config_decode_type  config_out,
  input wire logic                            port_g_bit5_input_out,
  input wire logic                            internal_rc_clock_enable_out,
  input wire logic                            device_reset_out,
  input wire logic                            wake_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  // ==========================================================
  // Sequences
  sequence restart_s;
    wdt_events_in.clear_instr || wdt_events_in.sleep_instr;
  endsequence
  // Stack and pin resets are kept apart from restarts by the bench
  sequence quiet_s;
    !wake_out && !device_reset_out;
  endsequence
  // ==========================================================
  // Assertions
  chk_pin_input_gate: assert property (port_g_bit5_input_out == (!config_out.reset_pin_enable && port_g_bit5_input_in))
    else $error("pin input gating wrong");
  chk_pin_reset_taken: assert property (config_out.reset_pin_enable && !master_reset_pin_n_in |=> device_reset_out)
    else $error("reset pin ignored");
  chk_wake_when_asleep: assert property (wake_out |-> $past(sleeping_in))
    else $error("wake while awake");
  chk_wake_needs_osc: assert property (wake_out |-> $past(internal_rc_clock_enable_out, 2))
    else $error("wake without oscillator");
  chk_osc_off_quiet: assert property (!internal_rc_clock_enable_out [*3] |=> !wake_out)
    else $error("wake while watchdog off");
  chk_restart_holds_off: assert property (restart_s |-> ##3 quiet_s [*2])
    else $error("expiry too soon after restart");
  chk_blocked_keeps: assert property (table_read_in && table_blocked_out |=> $stable(table_data_out))
    else $error("blocked read changed data");
  chk_internal_free: assert property (table_read_in && !table_from_external_in |-> !table_blocked_out)
    else $error("internal read blocked");
endmodule
bind config_fuses_and_watchdog config_fuses_and_watchdog_checker config_fuses_and_watchdog_checker_i (.clk_in,
  .reset_in, .table_read_in, .table_from_external_in, .table_data_out, .table_blocked_out, .wdt_events_in,
  .sleeping_in, .master_reset_pin_n_in, .port_g_bit5_input_in, .config_out, .port_g_bit5_input_out,
  .internal_rc_clock_enable_out, .device_reset_out, .wake_out);
`default_nettype wire

/* tb/config_fuses_and_watchdog_test.sv */
// Testbench: table reads, programming, pin decode and watchdog timing.
// Assumes the package constants; base tick shortened to 4 cycles.
`timescale 1ns/1ps
`default_nettype none
module config_fuses_and_watchdog_test;
  import cfg_wdt_pkg::*;
  localparam logic [10:0] pid = 11'h35a;  // Arbitrary value
  localparam logic [4:0]  rev = 5'h0c;    // Arbitrary value
  logic clk_in, reset_in, prog_write_in, table_read_in, table_from_external_in, sfr_write_in;
  logic sleeping_in, stack_fault_in, master_reset_pin_n_in, port_g_bit5_input_in, b;
  logic port_g_bit5_input_out, table_blocked_out, table_read_protect_out;
  logic internal_rc_clock_enable_out, device_reset_out, wake_out;
  logic [21:0]       prog_addr_in, table_addr_in;
  logic [7:0]        prog_data_in, sfr_wdata_in, table_data_out, sfr_rdata_out, d, p;
  logic [1:0]        sfr_addr_in;
  wdt_clear_type     wdt_events_in;
  config_decode_type config_out;
  int                failures = 0, n_tests = 0, cyc = 0, n;
  logic [21:0] ra[8] = '{22'h300003, 22'h300004, 22'h300005, 22'h300006, 22'h300008, 22'h30000c,
                         22'h3ffffe, 22'h3fffff};
  logic [7:0]  re[8] = '{8'h1f, 8'hc3, 8'h81, 8'h81, 8'h01, 8'h01, {pid[2:0], rev}, pid[10:3]};
  logic [7:0]  wb[4] = '{8'h0f, 8'h07, 8'h03, 8'h01};
  int          ps[4] = '{7, 3, 1, 0};

  config_fuses_and_watchdog #(.base_cycles(4), .part_identifier(pid), .silicon_revision(rev))
    config_fuses_and_watchdog_i (.*);

  // ==========================================================
  // Clock and cycle ceiling
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      failures++;
      finish_test();
    end
  end

  // ==========================================================
  // Access tasks
  task automatic tick(int k = 1);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic prog(logic [21:0] a, logic [7:0] v);
    prog_addr_in = a;
    prog_data_in = v;
    prog_write_in = 1'b1;
    tick();
    prog_write_in = 1'b0;
    tick();
  endtask
  task automatic tread(logic [21:0] a, logic ext);
    p = d;
    table_addr_in = a;
    table_from_external_in = ext;
    table_read_in = 1'b1;
    #1 b = table_blocked_out;
    tick();
    d = table_data_out;
    table_read_in = 1'b0;
    tick();
  endtask
  task automatic swr(logic [7:0] v);
    sfr_addr_in = sfr_watchdog_control;
    sfr_wdata_in = v;
    sfr_write_in = 1'b1;
    tick();
    sfr_write_in = 1'b0;
    tick();
  endtask
  task automatic srd(logic [1:0] a);
    sfr_addr_in = a;
    tick();
    d = sfr_rdata_out;
  endtask
  task automatic pulse(int i);
    wdt_events_in = 4'(1 << i);
    tick();
    wdt_events_in = '0;
  endtask
  // Waits for a watchdog reset, n = cycles spent
  task automatic wait_rst(int lim);
    n = 0;
    while (device_reset_out !== 1'b1 && n < lim)
    begin
      tick();
      n++;
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {reset_in, prog_write_in, table_read_in, table_from_external_in, sfr_write_in} = 5'h10;
    {sleeping_in, stack_fault_in, master_reset_pin_n_in, port_g_bit5_input_in} = 4'h3;
    {prog_addr_in, table_addr_in, prog_data_in, sfr_wdata_in, sfr_addr_in, d} = '0;
    wdt_events_in = '0;
    tick(2);
    reset_in = 1'b0;
    srd(sfr_watchdog_control);
    check("control reset", d, 8'h00);
    foreach (ra[i])
    begin
      tread(ra[i], 1'b0);
      check("erased byte", d, re[i]);
    end
    check("decode erased", config_out, 7'h40);
    check("protect erased", table_read_protect_out, 0);
    check("pin input off", port_g_bit5_input_out, 0);
    master_reset_pin_n_in = 1'b0;
    tick();
    master_reset_pin_n_in = 1'b1;
    check("pin reset", device_reset_out, 1);
    tick(2);
    stack_fault_in = 1'b1;
    tick();
    stack_fault_in = 1'b0;
    check("stack reset", device_reset_out, 1);
    prog(22'h300006, 8'h00);
    stack_fault_in = 1'b1;
    tick();
    stack_fault_in = 1'b0;
    check("stack ignored", device_reset_out, 0);
    prog(22'h300005, 8'h00);
    master_reset_pin_n_in = 1'b0;
    tick();
    master_reset_pin_n_in = 1'b1;
    check("pin ignored", device_reset_out, 0);
    check("pin input on", port_g_bit5_input_out, 1);
    // Clear-only programming: a later write of ones changes nothing
    prog(22'h300008, 8'h00);
    prog(22'h300008, 8'hff);
    tread(22'h300008, 1'b0);
    check("protect byte", d, 8'h00);
    check("decode mcu", config_out, 7'h0d);
    prog(22'h30000c, 8'h00);
    check("protect out", table_read_protect_out, 1);
    tread(22'h000100, 1'b1);
    check("mcu unblocked", b, 0);
    prog(22'h300004, 8'hc1);
    check("decode boot", config_out, 7'h15);
    // Non-zero data first, so a blocked read that leaks would show
    tread(22'h3fffff, 1'b0);
    tread(22'h0007ff, 1'b1);
    check("boot blocked", {b, d}, {1'b1, p});
    tread(22'h000800, 1'b1);
    check("above boot", b, 0);
    prog(22'h300004, 8'hc0);
    tread(22'h3fffff, 1'b0);
    tread(22'h0ff000, 1'b1);
    check("ext blocked", {b, d}, {1'b1, p});
    // Watchdog: configuration enable on
    swr(8'hff);
    srd(sfr_watchdog_control);
    check("control bits", d, 8'h01);
    swr(8'h00);
    check("osc on", internal_rc_clock_enable_out, 1);
    foreach (wb[i])
    begin
      prog(22'h300003, wb[i]);
      pulse(2);
      wait_rst(600);
      check("period", n >= (4 << ps[i]) && n <= (4 << ps[i]) + 3, 1);
    end
    srd(sfr_reset_cause);
    check("flag after expiry", d[bit_timeout_flag], 0);
    pulse(2);
    srd(sfr_reset_cause);
    check("flag after clear", d[bit_timeout_flag], 1);
    for (int i = 0; i < 4; i++)
      repeat (8)
      begin
        pulse(i);
        check("restart", device_reset_out, 0);
        tick();
        check("restart", device_reset_out, 0);
      end
    sleeping_in = 1'b1;
    n = 0;
    while (wake_out !== 1'b1 && n < 20)
    begin
      tick();
      n++;
    end
    check("wake", wake_out, 1);
    sleeping_in = 1'b0;
    // Watchdog: configuration enable off, software bit in charge
    prog(22'h300003, 8'h00);
    pulse(2);
    check("osc off", internal_rc_clock_enable_out, 0);
    wait_rst(40);
    check("idle", n, 40);
    swr(8'h01);
    check("osc sw", internal_rc_clock_enable_out, 1);
    wait_rst(40);
    check("sw expiry", device_reset_out, 1);
    swr(8'h00);
    finish_test();
  end
endmodule
`default_nettype wire
